//--- rtc_defs.svh
// register indices, field positions, reset values and timing figures for the clock block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// register indices; the byte address is four times the index
`define RTC_IDX_CTRL       6'h00
`define RTC_IDX_TRIM       6'h01
`define RTC_IDX_SEC        6'h02
`define RTC_IDX_MIN        6'h03
`define RTC_IDX_HOUR       6'h04
`define RTC_IDX_DOW        6'h05
`define RTC_IDX_DATE       6'h06
`define RTC_IDX_MONTH      6'h07
`define RTC_IDX_YEAR       6'h08
`define RTC_IDX_COMP       6'h0b

// field positions
`define RTC_CTRL_RD        0
`define RTC_CTRL_WL        1
`define RTC_CTRL_CAL       2
`define RTC_COMP_CHG       2
`define RTC_TRIM_SIGN      5
`define RTC_TRIM_MAG_W     5

// reset values
`define RTC_CTRL_RST       3'h0
`define RTC_TRIM_RST       6'h00
`define RTC_COMP_RST       1'b0

// bcd limits of each field
`define RTC_BCD_NINE       4'h9
`define RTC_SEC_MIN        8'h00
`define RTC_SEC_MAX        8'h59
`define RTC_MIN_MIN        8'h00
`define RTC_MIN_MAX        8'h59
`define RTC_HOUR_MIN       8'h00
`define RTC_HOUR_MAX       8'h23
`define RTC_DOW_MIN        8'h01
`define RTC_DOW_MAX        8'h07
`define RTC_DATE_MIN       8'h01
`define RTC_DAYS_31        8'h31
`define RTC_DAYS_30        8'h30
`define RTC_DAYS_29        8'h29
`define RTC_DAYS_28        8'h28
`define RTC_MONTH_MIN      8'h01
`define RTC_MONTH_MAX      8'h12
`define RTC_YEAR_MIN       8'h00
`define RTC_YEAR_MAX       8'h99
`define RTC_FEB            8'h02
`define RTC_APR            8'h04
`define RTC_JUN            8'h06
`define RTC_SEP            8'h09
`define RTC_NOV            8'h11
`define RTC_LEAP_U0        4'h0
`define RTC_LEAP_U4        4'h4
`define RTC_LEAP_U8        4'h8
`define RTC_LEAP_U2        4'h2
`define RTC_LEAP_U6        4'h6

// crystal chain: 32768 edges per second, 15-bit divider
`define RTC_XTAL_HZ        32768
`define RTC_DIV_W          15
`define RTC_CAL_HZ         512
// divider bit that toggles at the calibration rate: 32768 / 512 = 64 = 2**6
`define RTC_CAL_BIT        5
`define RTC_TRIM_SLOT      6'h00
// trim window of 64 seconds; 9 pulses per step in 2**21 edges is about 4.3 ppm
`define RTC_TRIM_WIN_MAX   6'h3f
`define RTC_TRIM_PER_STEP  9'h009
`define RTC_STEP_NONE      2'h0
`define RTC_STEP_ONE       2'h1
`define RTC_STEP_TWO       2'h2

`endif

//--- rtc_pkg.sv
// types shared by the clock block
package rtc_pkg;
	typedef logic [7:0] rtc_bcd_t;
	// time fields in holding and core order
	typedef enum {
		RTC_F_SEC,
		RTC_F_MIN,
		RTC_F_HOUR,
		RTC_F_DOW,
		RTC_F_DATE,
		RTC_F_MONTH,
		RTC_F_YEAR,
		RTC_F_NUM
	} rtc_field_e;
endpackage

//--- rtc_bcd_counter.sv
// one bcd time field of the timekeeper core with load and wrap
`include "rtc_defs.svh"
module rtc_bcd_counter
	import rtc_pkg::*;
(
	input  wire logic     I_CLK,
	input  wire logic     I_RST,
	input  wire logic     i_inc,
	input  wire logic     i_load,
	input  wire rtc_bcd_t i_load_val,
	input  wire rtc_bcd_t i_min,
	input  wire rtc_bcd_t i_max,
	output rtc_bcd_t      o_val,
	output logic          o_wrap
);
	rtc_bcd_t val_reg;
	rtc_bcd_t val_next;
	logic     at_max;

	// >= rather than == so a date left above a shorter month still rolls
	assign at_max = (val_reg >= i_max);
	assign o_wrap = i_inc & ~i_load & at_max;
	assign o_val  = val_reg;

	// bcd increment with rollover to the field minimum
	always_comb
	begin
		val_next = val_reg;
		if (i_load)
			val_next = i_load_val;
		else if (i_inc)
		begin
			if (at_max)
				val_next = i_min;
			else if (val_reg[3:0] == `RTC_BCD_NINE)
				val_next = {val_reg[7:4] + 4'h1, 4'h0};
			else
				val_next = {val_reg[7:4], val_reg[3:0] + 4'h1};
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			val_reg <= i_min;
		else
			val_reg <= val_next;
	end
endmodule

//--- rtc_timekeeper.sv
// real-time clock: crystal divider with trim, bcd core, holding registers, apb slave
//
// Notes on behaviour
// [R1] divide crystal edges down to one-second tick
// [R2] readable writable holding registers for all fields
// [R3] read bit rising copies core into holding
// [R4] pending tick lands in core before capture
// [R5] holding frozen until read bit cleared
// [R6] write lock keeps holding registers from overwrite; a lock set in the same write as the read bit still lets the snapshot in
// [R7] clearing write lock loads holding into core
// [R8] host writes only legal time values
// [R9] core advances every tick unless locked
// [R10] companion bit two drives backup charge enable
// [R11] lithium systems keep charge enable cleared
// [R12] calibration bit gives shared pin to calibration
// [R13] calibration drives 512 Hz square on pin
// [R14] trim adds or removes divider pulses
// [R15] sign one adds pulses, zero removes
// [R16] trim magnitude and sign in trim register
// [R17] trim writes accepted only in calibration mode
// [R18] clearing calibration returns pin to comparator
// [R19] each trim step about 4.29 ppm
// [R20] calibration enable is control bit two
// [R21] read bit 0, lock bit 1, reset zero
// [R22] bcd fields with correct calendar rollover
`include "rtc_defs.svh"
module rtc_timekeeper
	import rtc_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_XTAL,
	input  wire logic        I_PF_CMP,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic [31:0]      O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic             O_TRIM_OR_PF,
	output logic             O_BACKUP_CHARGE_EN
);
	localparam int NF = int'(RTC_F_NUM);

	// control, trim and companion registers
	logic [2:0]                 ctrl_reg;
	logic [2:0]                 ctrl_next;
	logic [`RTC_TRIM_MAG_W-1:0] trim_mag_reg;
	logic [`RTC_TRIM_MAG_W-1:0] trim_mag_next;
	logic                       trim_sign_reg;
	logic                       trim_sign_next;
	logic                       chg_reg;
	logic                       chg_next;
	rtc_bcd_t                   hold_reg [NF];
	rtc_bcd_t                   hold_next [NF];
	logic                       snap_reg;
	logic                       snap_next;
	logic [31:0]                rdata_reg;
	logic [31:0]                rdata_next;
	logic                       pin_reg;
	logic                       pin_next;

	// divider and trim state
	logic                       xtal_reg;
	logic [`RTC_DIV_W-1:0]      div_reg;
	logic [`RTC_DIV_W-1:0]      div_next;
	logic [5:0]                 win_reg;
	logic [5:0]                 win_next;
	logic [8:0]                 pend_reg;
	logic [8:0]                 pend_next;

	// bus decode and core wires
	logic [5:0]                 idx;
	logic                       addr_ok;
	logic                       acc;
	logic                       wr;
	logic                       rd_rise;
	logic                       wl_fall;
	logic                       xtal_rise;
	logic [1:0]                 step;
	logic [`RTC_DIV_W:0]        div_sum;
	logic                       sec_tick;
	logic                       leap;
	rtc_bcd_t                   date_max;
	rtc_bcd_t                   core_val [NF];
	rtc_bcd_t                   f_min [NF];
	rtc_bcd_t                   f_max [NF];
	logic [NF-1:0]              f_inc;
	logic [NF-1:0]              f_wrap;

	// zero-wait slave: every access completes in its first access cycle
	assign O_PREADY  = 1'b1;
	assign idx       = I_PADDR[7:2];
	assign acc       = I_PSEL & I_PENABLE;
	assign wr        = acc & I_PWRITE & addr_ok;
	assign O_PSLVERR = acc & ~addr_ok;
	assign O_PRDATA  = rdata_reg;

	// address decode; misaligned or unmapped addresses answer with an error
	always_comb
	begin
		addr_ok = 1'b0;
		if (I_PADDR[1:0] == 2'h0)
		begin
			case (idx)
				`RTC_IDX_CTRL, `RTC_IDX_TRIM, `RTC_IDX_SEC, `RTC_IDX_MIN,
				`RTC_IDX_HOUR, `RTC_IDX_DOW, `RTC_IDX_DATE, `RTC_IDX_MONTH,
				`RTC_IDX_YEAR, `RTC_IDX_COMP: addr_ok = 1'b1;
				default: addr_ok = 1'b0;
			endcase
		end
	end

	// [R3] read bit rising edge
	assign rd_rise = wr & (idx == `RTC_IDX_CTRL) & I_PWDATA[`RTC_CTRL_RD] & ~ctrl_reg[`RTC_CTRL_RD];
	// [R7] lock falling edge
	assign wl_fall = wr & (idx == `RTC_IDX_CTRL) & ~I_PWDATA[`RTC_CTRL_WL] & ctrl_reg[`RTC_CTRL_WL];

	// software-facing registers and read data
	always_comb
	begin
		ctrl_next      = ctrl_reg;
		trim_mag_next  = trim_mag_reg;
		trim_sign_next = trim_sign_reg;
		chg_next       = chg_reg;
		hold_next      = hold_reg;
		rdata_next     = rdata_reg;
		// capture a cycle after the read bit rose so a tick of that cycle is already in
		// [R4] tick before capture
		// [R5] one copy per rise
		// [R6] no snapshot if the lock bit was already set before the write that raises the read bit
		snap_next      = rd_rise & ~ctrl_reg[`RTC_CTRL_WL];
		// [R3] copy core into holding
		if (snap_reg)
			hold_next = core_val;
		if (wr)
		begin
			case (idx)
				// [R21] control bits
				`RTC_IDX_CTRL: ctrl_next = I_PWDATA[2:0];
				`RTC_IDX_TRIM:
				begin
					// [R17] trim writes gated
					if (ctrl_reg[`RTC_CTRL_CAL])
					begin
						// [R16] trim fields
						trim_mag_next  = I_PWDATA[`RTC_TRIM_MAG_W-1:0];
						trim_sign_next = I_PWDATA[`RTC_TRIM_SIGN];
					end
				end
				// [R10] charge enable bit
				`RTC_IDX_COMP: chg_next = I_PWDATA[`RTC_COMP_CHG];
				// [R2] holding registers written
				default: hold_next[int'(idx) - int'(`RTC_IDX_SEC)] = I_PWDATA[7:0];
			endcase
		end
		// read data is fetched in the setup cycle so it stands through the access cycle
		if (I_PSEL & ~I_PENABLE)
		begin
			rdata_next = 32'h0000_0000;
			case (idx)
				`RTC_IDX_CTRL: rdata_next[2:0] = ctrl_reg;
				`RTC_IDX_TRIM: rdata_next[5:0] = {trim_sign_reg, trim_mag_reg};
				`RTC_IDX_COMP: rdata_next[`RTC_COMP_CHG] = chg_reg;
				`RTC_IDX_SEC, `RTC_IDX_MIN, `RTC_IDX_HOUR, `RTC_IDX_DOW,
				`RTC_IDX_DATE, `RTC_IDX_MONTH, `RTC_IDX_YEAR:
					rdata_next[7:0] = hold_reg[int'(idx) - int'(`RTC_IDX_SEC)];
				default: rdata_next = 32'h0000_0000;
			endcase
			if (~addr_ok) // a misaligned word would otherwise show its neighbour
				rdata_next = 32'h0000_0000;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			ctrl_reg      <= `RTC_CTRL_RST;
			{trim_sign_reg, trim_mag_reg} <= `RTC_TRIM_RST;
			chg_reg       <= `RTC_COMP_RST;
			snap_reg      <= 1'b0;
			rdata_reg     <= 32'h0000_0000;
			hold_reg      <= '{default: 8'h00};
		end
		else
		begin
			ctrl_reg      <= ctrl_next;
			trim_mag_reg  <= trim_mag_next;
			trim_sign_reg <= trim_sign_next;
			chg_reg       <= chg_next;
			snap_reg      <= snap_next;
			rdata_reg     <= rdata_next;
			hold_reg      <= hold_next;
		end
	end

	// crystal edge: the pin is already synchronous, one flop gives the edge
	assign xtal_rise = I_XTAL & ~xtal_reg;
	assign div_sum   = {1'b0, div_reg} + {{(`RTC_DIV_W - 1){1'b0}}, step};
	// [R1] one second per wrap
	assign sec_tick  = xtal_rise & div_sum[`RTC_DIV_W];

	// trim: each 64 s window, added pulses come one per 64-count divider slot, removed ones back to back in one slot
	always_comb
	begin
		step      = `RTC_STEP_ONE;
		pend_next = pend_reg;
		win_next  = win_reg;
		div_next  = div_reg;
		if (xtal_rise)
		begin
			// [R14] add or drop a pulse
			if ((div_reg[5:0] == `RTC_TRIM_SLOT) && (pend_reg != 9'h000))
			begin
				// [R15] sign picks direction
				step      = trim_sign_reg ? `RTC_STEP_TWO : `RTC_STEP_NONE;
				pend_next = pend_reg - 9'h001;
			end
			div_next = div_sum[`RTC_DIV_W-1:0];
		end
		if (sec_tick)
		begin
			win_next = win_reg + 6'h01;
			// [R19] steps per window
			if (win_reg == `RTC_TRIM_WIN_MAX)
				pend_next = {4'h0, trim_mag_reg} * `RTC_TRIM_PER_STEP;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			xtal_reg <= 1'b0;
			div_reg  <= '0;
			win_reg  <= 6'h00;
			pend_reg <= 9'h000;
		end
		else
		begin
			xtal_reg <= I_XTAL;
			div_reg  <= div_next;
			win_reg  <= win_next;
			pend_reg <= pend_next;
		end
	end

	// leap years in 2000-2099: bcd year divisible by four
	assign leap = (~core_val[RTC_F_YEAR][4] & ((core_val[RTC_F_YEAR][3:0] == `RTC_LEAP_U0)
		| (core_val[RTC_F_YEAR][3:0] == `RTC_LEAP_U4) | (core_val[RTC_F_YEAR][3:0] == `RTC_LEAP_U8)))
		| (core_val[RTC_F_YEAR][4] & ((core_val[RTC_F_YEAR][3:0] == `RTC_LEAP_U2)
		| (core_val[RTC_F_YEAR][3:0] == `RTC_LEAP_U6)));

	// [R22] month lengths and carry chain
	always_comb
	begin
		case (core_val[RTC_F_MONTH])
			`RTC_FEB: date_max = leap ? `RTC_DAYS_29 : `RTC_DAYS_28;
			`RTC_APR, `RTC_JUN, `RTC_SEP, `RTC_NOV: date_max = `RTC_DAYS_30;
			default: date_max = `RTC_DAYS_31;
		endcase
		f_min[RTC_F_SEC]   = `RTC_SEC_MIN;
		f_max[RTC_F_SEC]   = `RTC_SEC_MAX;
		f_min[RTC_F_MIN]   = `RTC_MIN_MIN;
		f_max[RTC_F_MIN]   = `RTC_MIN_MAX;
		f_min[RTC_F_HOUR]  = `RTC_HOUR_MIN;
		f_max[RTC_F_HOUR]  = `RTC_HOUR_MAX;
		f_min[RTC_F_DOW]   = `RTC_DOW_MIN;
		f_max[RTC_F_DOW]   = `RTC_DOW_MAX;
		f_min[RTC_F_DATE]  = `RTC_DATE_MIN;
		f_max[RTC_F_DATE]  = date_max;
		f_min[RTC_F_MONTH] = `RTC_MONTH_MIN;
		f_max[RTC_F_MONTH] = `RTC_MONTH_MAX;
		f_min[RTC_F_YEAR]  = `RTC_YEAR_MIN;
		f_max[RTC_F_YEAR]  = `RTC_YEAR_MAX;
		// [R9] core halts while locked
		f_inc[RTC_F_SEC]   = sec_tick & ~ctrl_reg[`RTC_CTRL_WL];
		f_inc[RTC_F_MIN]   = f_wrap[RTC_F_SEC];
		f_inc[RTC_F_HOUR]  = f_wrap[RTC_F_MIN];
		f_inc[RTC_F_DOW]   = f_wrap[RTC_F_HOUR];
		f_inc[RTC_F_DATE]  = f_wrap[RTC_F_HOUR];
		f_inc[RTC_F_MONTH] = f_wrap[RTC_F_DATE];
		f_inc[RTC_F_YEAR]  = f_wrap[RTC_F_MONTH];
	end

	// one bcd counter per field; the lock release loads all of them at once
	genvar gi;
	generate
		for (gi = 0; gi < NF; gi++)
		begin : g_field
			rtc_bcd_counter u_cnt (
				.I_CLK      (I_CLK),
				.I_RST      (I_RST),
				.i_inc      (f_inc[gi]),
				.i_load     (wl_fall),
				.i_load_val (hold_reg[gi]),
				.i_min      (f_min[gi]),
				.i_max      (f_max[gi]),
				.o_val      (core_val[gi]),
				.o_wrap     (f_wrap[gi])
			);
		end
	endgenerate

	// shared pin; registered so the pin never glitches when the mode changes
	always_comb
	begin
		// [R12] calibration owns the pin
		// [R20] mode bit two
		if (ctrl_reg[`RTC_CTRL_CAL])
			// [R13] 512 Hz square
			pin_next = div_reg[`RTC_CAL_BIT];
		else
			// [R18] comparator restored
			pin_next = I_PF_CMP;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			pin_reg <= 1'b0;
		else
			pin_reg <= pin_next;
	end

	assign O_TRIM_OR_PF       = pin_reg;
	// [R10] charge source switch
	assign O_BACKUP_CHARGE_EN = chg_reg;
endmodule

//--- rtc_timekeeper_assertions.sv
// checker for bus decode, shared pin and charge output of the clock block
`include "rtc_defs.svh"
module rtc_chk (
	input wire logic        I_CLK,
	input wire logic        I_RST,
	input wire logic        I_XTAL,
	input wire logic        I_PF_CMP,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [7:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic        O_TRIM_OR_PF,
	input wire logic        O_BACKUP_CHARGE_EN
);
	logic        bad;
	logic        wr_ok;
	logic        cal_reg;
	logic        cal_next;
	logic        chg_reg;
	logic        chg_next;
	logic        xt_reg;
	logic        pin_reg;
	logic [15:0] rise_reg;
	logic [15:0] rise_next;

	// misaligned words and holes in the map answer with an error
	assign bad = (I_PADDR[1:0] != 2'h0)
		|| (I_PADDR[7:2] > `RTC_IDX_YEAR && I_PADDR[7:2] != `RTC_IDX_COMP);
	assign wr_ok = I_PSEL && I_PENABLE && I_PWRITE && !bad;

	// shadow bits, and crystal rises since the pin last moved in calibration
	always_comb
	begin
		cal_next = cal_reg;
		chg_next = chg_reg;
		if (wr_ok && I_PADDR == 8'h00)
			cal_next = I_PWDATA[`RTC_CTRL_CAL];
		if (wr_ok && I_PADDR == 8'h2c)
			chg_next = I_PWDATA[`RTC_COMP_CHG];
		rise_next = (!cal_reg || O_TRIM_OR_PF != pin_reg) ? 16'h0
			: rise_reg + 16'(I_XTAL && !xt_reg);
	end

	// shadows clear with the design so no check straddles a reset
	always_ff @(posedge I_CLK)
	begin
		cal_reg <= I_RST ? 1'b0 : cal_next;
		chg_reg <= I_RST ? 1'b0 : chg_next;
		rise_reg <= I_RST ? 16'h0 : rise_next;
		xt_reg <= I_XTAL;
		pin_reg <= O_TRIM_OR_PF;
	end

	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	sequence s_access;
		I_PSEL && I_PENABLE;
	endsequence
	sequence s_rd_access;
		s_access ##0 !I_PWRITE;
	endsequence

	a_ready_high: assert property (O_PREADY)
		else $error("ready low");
	a_err_decode: assert property (s_access |-> O_PSLVERR == bad)
		else $error("error answer wrong for address");
	a_err_idle: assert property (!(I_PSEL && I_PENABLE) |-> !O_PSLVERR)
		else $error("error outside access");
	a_err_no_data: assert property (O_PSLVERR |-> O_PRDATA == 32'h0)
		else $error("data with error answer");
	a_rd_stands: assert property (s_rd_access |=> $stable(O_PRDATA))
		else $error("read data moved after access");
	a_pin_follows_pf: assert property (!cal_reg && !$past(cal_reg) && !$past(I_RST)
		|-> O_TRIM_OR_PF == $past(I_PF_CMP)) else $error("pin not power fail");
	a_cal_pin_runs: assert property (cal_reg |-> rise_reg <= 16'h22)
		else $error("calibration square stalled");
	a_charge_follows: assert property ($stable(chg_reg)
		|-> O_BACKUP_CHARGE_EN == chg_reg) else $error("charge enable wrong");
endmodule

bind rtc_timekeeper rtc_chk u_chk (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_XTAL(I_XTAL), .I_PF_CMP(I_PF_CMP),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
	.I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_TRIM_OR_PF(O_TRIM_OR_PF),
	.O_BACKUP_CHARGE_EN(O_BACKUP_CHARGE_EN)
);

//--- rtc_xtal_model.sv
// crystal source: a free running square, HALF clocks per half period
module rtc_xtal_model #(
	parameter int HALF = 1
) (
	input  wire logic i_clk,
	output logic      o_xtal
);
	timeunit 1ns;
	timeprecision 1ns;
	int   cnt_reg = 0;
	logic xt_reg  = 1'b0;

	// the oscillator never stops, so there is no gating between seconds
	always_ff @(posedge i_clk)
	begin
		cnt_reg <= (cnt_reg + 1 >= HALF) ? 0 : cnt_reg + 1;
		if (cnt_reg + 1 >= HALF)
			xt_reg <= !xt_reg;
	end
	assign o_xtal = xt_reg;
endmodule

//--- testbench.sv
// self-checking bench for the clock block
`include "rtc_defs.svh"
module testbench
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic        err;
	} rtc_row_s;
	// crystal rises every 2 clocks, so a second is far shorter than real time
	localparam int SEC_CLKS  = 2 * `RTC_XTAL_HZ;
	localparam int HALF_CLKS = `RTC_XTAL_HZ / `RTC_CAL_HZ;
	logic        clk;
	logic        rst;
	logic        xtal;
	logic        pf;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        pin;
	logic        chg;
	logic        er;
	int          fails;
	int          n_checks;
	int          cyc;
	int          n;
	// legal time 23:59:59 day 7, 28 Feb of a common year, written while locked
	rtc_row_s    rows[12] = '{
		'{8'h00, 32'h2, 32'h2, 1'b0}, '{8'h08, 32'h59, 32'h59, 1'b0},
		'{8'h0c, 32'h59, 32'h59, 1'b0}, '{8'h10, 32'h23, 32'h23, 1'b0},
		'{8'h14, 32'h07, 32'h07, 1'b0}, '{8'h18, 32'h28, 32'h28, 1'b0},
		'{8'h1c, 32'h02, 32'h02, 1'b0}, '{8'h20, 32'h23, 32'h23, 1'b0},
		'{8'h2c, 32'h4, 32'h4, 1'b0}, '{8'h04, 32'h25, 32'h0, 1'b0},
		'{8'h24, 32'h5, 32'h0, 1'b1}, '{8'h0a, 32'h5, 32'h0, 1'b1}};
	rtc_bcd_t    t_set[7]  = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h23};
	rtc_bcd_t    t_next[7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h23};
	logic [7:0]  zero_at[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h2c};

	rtc_timekeeper DUT (
		.I_CLK(clk), .I_RST(rst), .I_XTAL(xtal), .I_PF_CMP(pf), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.O_TRIM_OR_PF(pin), .O_BACKUP_CHARGE_EN(chg));
	rtc_xtal_model #(.HALF(1)) u_xtal (.i_clk(clk), .o_xtal(xtal));

	// clock and cycles since reset release
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
		cyc <= rst ? 0 : cyc + 1;

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one transfer; an idle cycle follows so psel is never driven twice at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		// only the watchdog ends a wait for the answer
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask

	task check_time(input rtc_bcd_t e[7]);
		foreach (e[i])
		begin
			apb(1'b0, 8'(8'h08 + 4 * i), 32'h0);
			chk(rd, 32'(e[i]));
		end
	endtask

	task wait_edge(output int k);
		logic p;
		p = pin;
		k = 0;
		// the pin is looked at mid-cycle, where it has settled
		while (pin === p && k < 300)
		begin
			@(negedge clk);
			k++;
		end
		@(posedge clk);
	endtask

	task do_reset;
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
	endtask

	task report_and_stop;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pf = 1'b0;
		fails = 0;
		n_checks = 0;
		do_reset();
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk(32'(er), 32'(rows[i].err));
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
			chk(32'(er), 32'(rows[i].err));
		end
		chk(32'(chg), 32'h1);
		$display("test table done");
		// unlock loads the core, then a fresh snapshot
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		check_time(t_set);
		// the snapshot stays frozen across the first second tick
		while (cyc < SEC_CLKS + 400)
			@(posedge clk);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h59);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		check_time(t_next);
		$display("test tick done");
		// calibration: trim accepted both signs, square at the divided rate
		apb(1'b1, 8'h00, 32'h4);
		apb(1'b1, 8'h04, 32'h25);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h25);
		apb(1'b1, 8'h04, 32'h1f);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1f);
		wait_edge(n);
		wait_edge(n);
		wait_edge(n);
		chk(32'(n), 32'(HALF_CLKS));
		apb(1'b1, 8'h00, 32'h0);
		pf <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(pin), 32'h1);
		$display("test calibration done");
		// after reset the charge source is off, as a battery-backed system needs
		do_reset();
		foreach (zero_at[i])
		begin
			apb(1'b0, zero_at[i], 32'h0);
			chk(rd, 32'h0);
		end
		chk(32'(chg), 32'h0);
		$display("test reset done");
		report_and_stop();
	end

	// watchdog: the run needs about one simulated second plus a little
	initial
	begin
		repeat (SEC_CLKS + 5000) @(posedge clk);
		fails++;
		report_and_stop();
	end
endmodule
